// File: tpc_timer.sv
/*
 * One-channel timer/PWM unit with byte-coherent 16-bit counter and channel value registers, an Avalon-MM slave.
 * Assumes inputs synchronous to clk_sys and a master that holds each request until waitrequest is low.
 */
`timescale 1ns/100ps
`include "tpc_defs.svh"
module tpc_timer
  import tpc_pkg::*;
#(
  parameter int PS_W = 7 // prescaler counter width
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic [7:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic debug_halt, // debugger halt
  input wire logic analog_comparator_out, // comparator output
  input wire logic timer_ext_clock_pin, // external clock source
  input wire logic port_a_bit_zero_in, // pin level
  output logic port_a_bit_zero_out, // pin drive
  output logic port_a_bit_zero_oe, // pin enable
  input wire logic port_b_bit_five_in, // pin level
  output logic port_b_bit_five_out, // pin drive
  output logic port_b_bit_five_oe, // pin enable
  output logic timer_bus_clock_en // gate state
);
  generate
    if (PS_W < 7 || PS_W > 16) begin : g_bad_ps
      $error("prescaler width must be 7 to 16");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  logic gate_q, gate_d;
  logic [1:0] opt_q, opt_d;
  logic [7:0] tsc_q, tsc_d, csc_q, csc_d, rdata_q, rdata_d;
  tpc_word_type mod_q, mod_d, cnt_q, cnt_d, cv_q, cv_d, cvbuf_q, cvbuf_d;
  tpc_word_type clat_q, clat_d, vlat_q, vlat_d;
  logic [PS_W-1:0] pre_q, pre_d, ps_mask;
  logic [1:0] cvw_q, cvw_d, crd_q, crd_d, vrd_q, vrd_d;
  logic cvpend_q, cvpend_d, clat_v_q, clat_v_d, vlat_v_q, vlat_v_d;
  logic ack_q, ack_d, ext_q, ext_d, cap_q, cap_d, out_q, out_d;
  logic req, first, acc, wr, rd, src_ev, run, tick, pwm_pt, cap_ev, match;
  logic [1:0] clk_sel, edge_sel;
  tpc_mode_type mode;
  tpc_word_type top, pre_top, cnt_nx;
  tpc_pin_if pin ();

  tpc_pin_route u_route (
    .pin(pin.route),
    .cmp_out(analog_comparator_out),
    .pa_in(port_a_bit_zero_in),
    .pa_out(port_a_bit_zero_out),
    .pa_oe(port_a_bit_zero_oe),
    .pb_in(port_b_bit_five_in),
    .pb_out(port_b_bit_five_out),
    .pb_oe(port_b_bit_five_oe)
  );

  assign pin.route_cmp = opt_q[`TPC_OPT_ROUTE];
  assign pin.pos_alt = opt_q[`TPC_OPT_POS];
  assign pin.ch_out = out_q;
  assign pin.ch_oe = (mode != tpc_m_ic);
  assign timer_bus_clock_en = gate_q;

  ////////////////////////////////////////////////////////////////////////////
  // one wait state: read data are captured in the stall cycle, so they stand at the accepting edge
  assign req = avs_read | avs_write;
  assign first = req & ~ack_q;
  assign acc = req & ack_q;
  assign avs_waitrequest = first;
  assign avs_readdata = {24'h0, rdata_q};
  assign wr = acc & avs_write & avs_byteenable[0];
  assign rd = first & avs_read;

  assign clk_sel = tsc_q[`TPC_TSC_CLK_HI:`TPC_TSC_CLK_LO];
  assign edge_sel = csc_q[`TPC_CSC_EDGE_HI:`TPC_CSC_EDGE_LO];
  assign mode = (csc_q[`TPC_CSC_MODE_HI:`TPC_CSC_MODE_LO] == `TPC_MODE_IC) ? tpc_m_ic :
                (csc_q[`TPC_CSC_MODE_HI:`TPC_CSC_MODE_LO] == `TPC_MODE_OC) ? tpc_m_oc : tpc_m_epwm;
  assign ps_mask = PS_W'((32'h1 << tsc_q[`TPC_TSC_PS_HI:`TPC_TSC_PS_LO]) - 32'h1);
  // the external pin is sampled on clk_sys, so it must be slower than half the bus rate
  assign src_ev = (clk_sel == `TPC_CLK_OFF) ? 1'b0 :
                  (clk_sel == `TPC_CLK_EXT) ? (timer_ext_clock_pin & ~ext_q) : 1'b1;
  assign run = gate_q & ~debug_halt & src_ev;
  assign tick = run & (pre_q == ps_mask);
  assign top = (mod_q == `TPC_RST_WORD) ? `TPC_FREE_TOP : mod_q;
  assign pre_top = (mod_q == `TPC_RST_WORD) ? `TPC_FREE_PRE : mod_q - `TPC_ONE_WORD;
  assign cnt_nx = (cnt_q == top) ? `TPC_RST_WORD : cnt_q + `TPC_ONE_WORD;
  assign pwm_pt = tick & (cnt_q == pre_top);
  assign match = tick & (cnt_nx == cv_q);
  assign cap_ev = gate_q & ~debug_halt &
                  ((edge_sel[0] & pin.cap_in & ~cap_q) | (edge_sel[1] & ~pin.cap_in & cap_q));

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    gate_d = gate_q;
    opt_d = opt_q;
    tsc_d = tsc_q;
    csc_d = csc_q;
    mod_d = mod_q;
    cnt_d = cnt_q;
    pre_d = pre_q;
    cv_d = cv_q;
    cvbuf_d = cvbuf_q;
    cvw_d = cvw_q;
    cvpend_d = cvpend_q;
    clat_d = clat_q;
    clat_v_d = clat_v_q;
    crd_d = crd_q;
    vlat_d = vlat_q;
    vlat_v_d = vlat_v_q;
    vrd_d = vrd_q;
    rdata_d = rdata_q;
    out_d = out_q;
    ack_d = first;
    ext_d = timer_ext_clock_pin;
    cap_d = pin.cap_in;

    if (run) begin
      pre_d = tick ? '0 : pre_q + PS_W'(1);
    end
    if (tick) begin
      cnt_d = cnt_nx;
    end

    // channel value transfer from the write buffer
    if (cvpend_q) begin
      if ((clk_sel == `TPC_CLK_OFF) || (mode == tpc_m_oc && tick) || (mode == tpc_m_epwm && pwm_pt)) begin
        cv_d = cvbuf_q;
        cvpend_d = 1'b0;
      end
    end
    if (mode == tpc_m_ic && cap_ev) begin
      cv_d = cnt_q;
      csc_d[`TPC_CSC_FLAG] = 1'b1;
    end
    if (mode == tpc_m_oc && match) begin
      csc_d[`TPC_CSC_FLAG] = 1'b1;
      out_d = (edge_sel == `TPC_EDGE_TOGGLE) ? ~out_q : (edge_sel == `TPC_EDGE_SET);
    end
    if (mode == tpc_m_epwm) begin
      out_d = (cnt_q < cv_q) ^ edge_sel[0];
    end

    // register writes
    if (wr) begin
      if (avs_address == `TPC_A_OPT) begin
        opt_d = avs_writedata[1:0];
      end else if (avs_address == `TPC_A_GATE) begin
        gate_d = avs_writedata[`TPC_GATE_BIT];
      end else if (!gate_q) begin
        // timer registers ignore writes while its clock is gated
      end else if (avs_address == `TPC_A_TSC) begin
        tsc_d = avs_writedata[7:0] & `TPC_TSC_MASK;
        cvw_d = 2'b00;
        if (debug_halt) begin
          clat_v_d = 1'b0;
          crd_d = 2'b00;
        end
      end else if (avs_address == `TPC_A_CNTH || avs_address == `TPC_A_CNTL) begin
        cnt_d = `TPC_RST_WORD;
        pre_d = '0;
        if (debug_halt) begin
          clat_v_d = 1'b0;
          crd_d = 2'b00;
        end
      end else if (avs_address == `TPC_A_MODH) begin
        mod_d[15:8] = avs_writedata[7:0];
      end else if (avs_address == `TPC_A_MODL) begin
        mod_d[7:0] = avs_writedata[7:0];
      end else if (avs_address == `TPC_A_CSC) begin
        csc_d[`TPC_CSC_MODE_HI:0] = avs_writedata[`TPC_CSC_MODE_HI:0];
        // writing 0 clears the flag, but a flag set in this cycle survives
        if (!avs_writedata[`TPC_CSC_FLAG] && !(mode == tpc_m_ic && cap_ev) && !(mode == tpc_m_oc && match)) begin
          csc_d[`TPC_CSC_FLAG] = 1'b0;
        end
        if (debug_halt) begin
          vlat_v_d = 1'b0;
          vrd_d = 2'b00;
        end
      end else if ((avs_address == `TPC_A_CVH || avs_address == `TPC_A_CVL) && mode != tpc_m_ic) begin
        // capture mode writes are dropped, software must not issue them
        if (avs_address == `TPC_A_CVH) begin
          cvbuf_d[15:8] = avs_writedata[7:0];
          cvw_d[`TPC_HI] = 1'b1;
        end else begin
          cvbuf_d[7:0] = avs_writedata[7:0];
          cvw_d[`TPC_LO] = 1'b1;
        end
        if (cvw_d == `TPC_BOTH) begin
          cvpend_d = 1'b1;
          cvw_d = 2'b00;
        end
      end
    end

    // register reads, taken in the stall cycle
    if (rd) begin
      rdata_d = `TPC_RST_BYTE;
      if (avs_address == `TPC_A_OPT) begin
        rdata_d = {6'h0, opt_q};
      end else if (avs_address == `TPC_A_GATE) begin
        rdata_d = {7'h0, gate_q};
      end else if (!gate_q) begin
        rdata_d = `TPC_RST_BYTE;
      end else if (avs_address == `TPC_A_TSC) begin
        rdata_d = tsc_q;
      end else if (avs_address == `TPC_A_CSC) begin
        rdata_d = csc_q;
      end else if (avs_address == `TPC_A_MODH) begin
        rdata_d = mod_q[15:8];
      end else if (avs_address == `TPC_A_MODL) begin
        rdata_d = mod_q[7:0];
      end else if (avs_address == `TPC_A_CNTH || avs_address == `TPC_A_CNTL) begin
        if (debug_halt) begin
          rdata_d = (avs_address == `TPC_A_CNTH) ? cnt_q[15:8] : cnt_q[7:0];
        end else begin
          clat_d = clat_v_q ? clat_q : cnt_q;
          rdata_d = (avs_address == `TPC_A_CNTH) ? clat_d[15:8] : clat_d[7:0];
          crd_d = crd_q | ((avs_address == `TPC_A_CNTH) ? 2'b10 : 2'b01);
          clat_v_d = (crd_d != `TPC_BOTH);
          crd_d = clat_v_d ? crd_d : 2'b00;
        end
      end else if (avs_address == `TPC_A_CVH || avs_address == `TPC_A_CVL) begin
        if (debug_halt) begin
          rdata_d = (avs_address == `TPC_A_CVH) ? cv_q[15:8] : cv_q[7:0];
        end else begin
          vlat_d = vlat_v_q ? vlat_q : cv_q;
          rdata_d = (avs_address == `TPC_A_CVH) ? vlat_d[15:8] : vlat_d[7:0];
          vrd_d = vrd_q | ((avs_address == `TPC_A_CVH) ? 2'b10 : 2'b01);
          vlat_v_d = (vrd_d != `TPC_BOTH);
          vrd_d = vlat_v_d ? vrd_d : 2'b00;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      gate_q <= `TPC_RST_GATE;
      opt_q <= `TPC_RST_OPT;
      tsc_q <= `TPC_RST_BYTE;
      csc_q <= `TPC_RST_BYTE;
      rdata_q <= `TPC_RST_BYTE;
      mod_q <= `TPC_RST_WORD;
      cnt_q <= `TPC_RST_WORD;
      cv_q <= `TPC_RST_WORD;
      cvbuf_q <= `TPC_RST_WORD;
      clat_q <= `TPC_RST_WORD;
      vlat_q <= `TPC_RST_WORD;
      pre_q <= '0;
      cvw_q <= 2'b00;
      crd_q <= 2'b00;
      vrd_q <= 2'b00;
      cvpend_q <= 1'b0;
      clat_v_q <= 1'b0;
      vlat_v_q <= 1'b0;
      ack_q <= 1'b0;
      ext_q <= 1'b0;
      cap_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
      opt_q <= opt_d;
      tsc_q <= tsc_d;
      csc_q <= csc_d;
      rdata_q <= rdata_d;
      mod_q <= mod_d;
      cnt_q <= cnt_d;
      cv_q <= cv_d;
      cvbuf_q <= cvbuf_d;
      clat_q <= clat_d;
      vlat_q <= vlat_d;
      pre_q <= pre_d;
      cvw_q <= cvw_d;
      crd_q <= crd_d;
      vrd_q <= vrd_d;
      cvpend_q <= cvpend_d;
      clat_v_q <= clat_v_d;
      vlat_v_q <= vlat_v_d;
      ack_q <= ack_d;
      ext_q <= ext_d;
      cap_q <= cap_d;
      out_q <= out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_cv_pending;
    cvpend_q && gate_q && clk_sel != `TPC_CLK_OFF;
  endsequence
  sequence s_halt_write(logic [7:0] a);
    wr && gate_q && debug_halt && avs_address == a;
  endsequence

  a_route_capture: assert property (pin.route_cmp |-> pin.cap_in == analog_comparator_out)
    else $error("capture input not taken from comparator");
  a_route_pin_off: assert property (pin.route_cmp |-> !port_a_bit_zero_oe && !port_b_bit_five_oe)
    else $error("channel pin driven while comparator routed");
  a_pos_select: assert property (!pin.route_cmp && pin.ch_oe |-> port_b_bit_five_oe == pin.pos_alt
                                 && port_a_bit_zero_oe == !pin.pos_alt)
    else $error("channel pin on wrong port");
  a_gate_reset: assert property ($rose(rst_b) |-> gate_q && timer_bus_clock_en)
    else $error("clock gate not set after reset");
  a_gate_stops: assert property (!gate_q && !wr |=> $stable(cnt_q))
    else $error("counter moved with clock gated");
  a_cnt_clear: assert property (wr && gate_q && (avs_address == `TPC_A_CNTH || avs_address == `TPC_A_CNTL)
                                |=> cnt_q == `TPC_RST_WORD && pre_q == '0)
    else $error("counter write did not clear counter and prescaler");
  a_halt_cnt_read: assert property (rd && gate_q && debug_halt && avs_address == `TPC_A_CNTL
                                    |=> rdata_q == $past(cnt_q[7:0]) ##1 avs_readdata[7:0] == $past(rdata_q))
    else $error("halted counter read not live");
  a_halt_cnt_unlatch: assert property (s_halt_write(`TPC_A_TSC) |=> !clat_v_q)
    else $error("counter read latch survived halted write");
  a_halt_cntw_unlatch: assert property (s_halt_write(`TPC_A_CNTL) |=> !clat_v_q)
    else $error("counter read latch survived halted counter write");
  a_halt_cv_read: assert property (rd && gate_q && debug_halt && avs_address == `TPC_A_CVH
                                   |=> rdata_q == $past(cv_q[15:8]))
    else $error("halted channel read not actual value");
  a_halt_cv_unlatch: assert property (s_halt_write(`TPC_A_CSC) |=> !vlat_v_q)
    else $error("channel read latch survived halted write");
  a_oc_load: assert property (s_cv_pending ##0 (mode == tpc_m_oc && tick)
                              |=> cv_q == $past(cvbuf_q) && !cvpend_q)
    else $error("output compare value not loaded at counter step");
  a_pwm_hold: assert property (s_cv_pending ##0 (mode == tpc_m_epwm && !pwm_pt) |=> $stable(cv_q))
    else $error("pwm value changed away from load point");
  a_pwm_load: assert property (s_cv_pending ##0 (mode == tpc_m_epwm && pwm_pt)
                               |=> cv_q == $past(cvbuf_q) && cnt_q == $past(top))
    else $error("pwm value not loaded at modulo step");
  a_read_latch: assert property (rd && gate_q && !debug_halt && !clat_v_q && avs_address == `TPC_A_CNTH
                                 |=> clat_v_q && clat_q == $past(cnt_q))
    else $error("counter pair not latched on first byte read");
  a_buf_wait: assert property (!cvpend_q && cvw_q != `TPC_BOTH && !(mode == tpc_m_ic && cap_ev)
                               ##1 !cvpend_q |-> $stable(cv_q))
    else $error("channel value changed before both bytes written");
endmodule : tpc_timer

// File: tpc_defs.svh
/*
 * Register offsets, field positions, reset values and codes of the timer/PWM unit.
 * Assumes a 32-bit Avalon-MM slave with byte addresses; each register sits in the low byte.
 */
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH

`define TPC_A_TSC 8'h00
`define TPC_A_CNTH 8'h04
`define TPC_A_CNTL 8'h08
`define TPC_A_MODH 8'h0c
`define TPC_A_MODL 8'h10
`define TPC_A_CSC 8'h14
`define TPC_A_CVH 8'h18
`define TPC_A_CVL 8'h1c
`define TPC_A_OPT 8'h20
`define TPC_A_GATE 8'h24

`define TPC_TSC_CLK_HI 4
`define TPC_TSC_CLK_LO 3
`define TPC_TSC_PS_HI 2
`define TPC_TSC_PS_LO 0
`define TPC_TSC_MASK 8'h1f
`define TPC_CSC_FLAG 7
`define TPC_CSC_MODE_HI 3
`define TPC_CSC_MODE_LO 2
`define TPC_CSC_EDGE_HI 1
`define TPC_CSC_EDGE_LO 0
`define TPC_CSC_MASK 8'h0f
`define TPC_OPT_ROUTE 0
`define TPC_OPT_POS 1
`define TPC_GATE_BIT 0

`define TPC_RST_BYTE 8'h00
`define TPC_RST_WORD 16'h0000
`define TPC_RST_OPT 2'h0
`define TPC_RST_GATE 1'b1
`define TPC_FREE_TOP 16'hffff
`define TPC_FREE_PRE 16'hfffe
`define TPC_ONE_WORD 16'h0001

`define TPC_CLK_OFF 2'h0
`define TPC_CLK_EXT 2'h3
`define TPC_MODE_IC 2'h0
`define TPC_MODE_OC 2'h1
`define TPC_EDGE_TOGGLE 2'h1
`define TPC_EDGE_CLEAR 2'h2
`define TPC_EDGE_SET 2'h3
`define TPC_BOTH 2'h3
`define TPC_HI 1
`define TPC_LO 0

`endif

// File: tpc_pkg.sv
/*
 * Types shared by the timer/PWM unit.
 * Assumes tpc_defs.svh supplies the numeric constants.
 */
package tpc_pkg;
  typedef enum logic [1:0] {tpc_m_ic, tpc_m_oc, tpc_m_epwm} tpc_mode_type;
  typedef logic [15:0] tpc_word_type;
endpackage : tpc_pkg

// File: tpc_pin_if.sv
/*
 * Carrier between the timer core and its pin routing.
 * Assumes both ends run on the same clock; all signals are levels.
 */
`timescale 1ns/100ps
interface tpc_pin_if;
  logic route_cmp;
  logic pos_alt;
  logic ch_out;
  logic ch_oe;
  logic cap_in;
  modport core (output route_cmp, output pos_alt, output ch_out, output ch_oe, input cap_in);
  modport route (input route_cmp, input pos_alt, input ch_out, input ch_oe, output cap_in);
endinterface : tpc_pin_if

// File: tpc_pin_route.sv
/*
 * Channel pin routing: comparator routing and pin position choice.
 * Assumes the pad logic resolves each pin from its output enable.
 */
`timescale 1ns/100ps
module tpc_pin_route (
  tpc_pin_if.route pin, // core side
  input wire logic cmp_out, // analog comparator output
  input wire logic pa_in, // port a bit zero level
  output logic pa_out, // port a bit zero drive
  output logic pa_oe, // port a bit zero enable
  input wire logic pb_in, // port b bit five level
  output logic pb_out, // port b bit five drive
  output logic pb_oe // port b bit five enable
);
  // routing overrides the channel configuration entirely
  assign pin.cap_in = pin.route_cmp ? cmp_out : (pin.pos_alt ? pb_in : pa_in);
  assign pa_out = pin.ch_out;
  assign pb_out = pin.ch_out;
  assign pa_oe = pin.ch_oe & ~pin.route_cmp & ~pin.pos_alt;
  assign pb_oe = pin.ch_oe & ~pin.route_cmp & pin.pos_alt;
endmodule : tpc_pin_route

// File: tpc_far_model.sv
/*
 * Far side of the timer: comparator output, external clock pin and the two channel pins.
 * Assumes the bench calls its tasks right after a rising edge of clk_sys.
 */
`timescale 1ns/100ps
module tpc_far_model (
  input wire logic clk_sys, // system clock
  input wire logic pa_out, // port a drive from the timer
  input wire logic pa_oe, // port a enable from the timer
  input wire logic pb_out, // port b drive from the timer
  input wire logic pb_oe, // port b enable from the timer
  output logic pa_in, // port a level seen by the timer
  output logic pb_in, // port b level seen by the timer
  output logic cmp_out, // comparator level
  output logic ext_clk // external clock pin
);
  logic float_q = 1'b0;
  initial begin
    cmp_out = 1'b0;
    ext_clk = 1'b0;
  end
  always @(posedge clk_sys) begin
    float_q <= ~float_q;
  end
  // no pull on the pads: an undriven pin toggles so a stale level cannot pass
  assign pa_in = pa_oe ? pa_out : float_q;
  assign pb_in = pb_oe ? pb_out : ~float_q;
  //////////////////////////////////////////////////////////////////////////////
  // clock stays low between pulses; each pulse is one source event
  task automatic ext_pulse();
    @(posedge clk_sys);
    ext_clk <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ext_clk <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : ext_pulse
  task automatic cmp_drive(input logic v);
    @(posedge clk_sys);
    cmp_out <= v;
    repeat (4) @(posedge clk_sys);
  endtask : cmp_drive
endmodule : tpc_far_model

// File: test_timer_pwm_coherency.sv
/*
 * Self-checking bench for the timer unit: bus tasks, a pin table, coherency cases.
 * Assumes tpc_far_model drives the comparator and the external clock pin.
 */
`timescale 1ns/100ps
`include "tpc_defs.svh"
module test_timer_pwm_coherency
  import tpc_pkg::*;
;
  logic clk_sys;
  logic rst_b;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic debug_halt;
  logic cmp_out;
  logic ext_clk;
  logic pa_in, pa_out, pa_oe;
  logic pb_in, pb_out, pb_oe;
  logic gate_en;
  int error_cnt = 0;
  int check_count = 0;
  // row layout: option bits, port a enable, port b enable
  logic [3:0] pin_rows [4] = '{4'h2, 4'h9, 4'h4, 4'hc};

  tpc_timer u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .debug_halt(debug_halt),
    .analog_comparator_out(cmp_out), .timer_ext_clock_pin(ext_clk), .port_a_bit_zero_in(pa_in),
    .port_a_bit_zero_out(pa_out), .port_a_bit_zero_oe(pa_oe), .port_b_bit_five_in(pb_in),
    .port_b_bit_five_out(pb_out), .port_b_bit_five_oe(pb_oe), .timer_bus_clock_en(gate_en));
  tpc_far_model u_far (.clk_sys(clk_sys), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out),
    .pb_oe(pb_oe), .pa_in(pa_in), .pb_in(pb_in), .cmp_out(cmp_out), .ext_clk(ext_clk));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp, input string msg);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask : chk1
  // holds the request until waitrequest is seen low at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    chk1(avs_waitrequest, 1'b0, "bus stall");
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk8(q, exp, msg);
  endtask : rdc
  task automatic pulses(input int n);
    repeat (n) u_far.ext_pulse();
  endtask : pulses
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    // the free running case alone needs about 65600 cycles
    #800000;
    error_cnt = error_cnt + 1;
    complete_run();
  end
  initial begin
    rst_b = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    debug_halt = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk1(gate_en, 1'b1, "gate reset");
    chk1(pa_oe, 1'b0, "pin reset");
    for (int i = 0; i < 4; i++) begin
      // ordinary cases need a driving mode, set once in the first pass of the loop
      if (i == 0) begin
        wr(`TPC_A_CSC, 8'h08);
      end
      wr(`TPC_A_OPT, {6'h00, pin_rows[i][3:2]});
      @(posedge clk_sys);
      chk1(pa_oe, pin_rows[i][1], "pa enable");
      chk1(pb_oe, pin_rows[i][0], "pb enable");
    end
    wr(`TPC_A_CSC, 8'h00);
    wr(`TPC_A_GATE, 8'h00);
    @(posedge clk_sys);
    chk1(gate_en, 1'b0, "gate off");
    wr(`TPC_A_MODL, 8'h55);
    rdc(`TPC_A_MODL, 8'h00, "gated read");
    wr(`TPC_A_GATE, 8'h01);
    rdc(`TPC_A_MODL, 8'h00, "gated write");
    // divide by two: a prescaler left uncleared would let the next pulse count
    wr(`TPC_A_TSC, 8'h19);
    wr(`TPC_A_CNTL, 8'h00);
    pulses(1);
    wr(`TPC_A_CNTH, 8'h00);
    pulses(1);
    rdc(`TPC_A_CNTL, 8'h00, "prescaler clear");
    rdc(`TPC_A_CNTH, 8'h00, "counter high");
    pulses(1);
    rdc(`TPC_A_CNTH, 8'h00, "counter high");
    rdc(`TPC_A_CNTL, 8'h01, "ext count");
    wr(`TPC_A_TSC, 8'h18);
    wr(`TPC_A_CNTL, 8'h00);
    pulses(3);
    rdc(`TPC_A_CNTH, 8'h00, "latch high");
    pulses(2);
    debug_halt <= 1'b1;
    rdc(`TPC_A_CNTL, 8'h05, "halt live");
    wr(`TPC_A_CNTL, 8'h00);
    rdc(`TPC_A_CNTL, 8'h00, "halt clear");
    rdc(`TPC_A_CNTH, 8'h00, "halt high");
    debug_halt <= 1'b0;
    pulses(1);
    rdc(`TPC_A_CNTH, 8'h00, "latch high");
    pulses(1);
    debug_halt <= 1'b1;
    wr(`TPC_A_TSC, 8'h18);
    debug_halt <= 1'b0;
    pulses(1);
    rdc(`TPC_A_CNTL, 8'h03, "latch reset");
    rdc(`TPC_A_CNTH, 8'h00, "counter high");
    rdc(`TPC_A_CNTH, 8'h00, "latch high");
    pulses(2);
    rdc(`TPC_A_CNTL, 8'h03, "latched low");
    wr(`TPC_A_CSC, 8'h05);
    wr(`TPC_A_CVH, 8'h12);
    pulses(1);
    rdc(`TPC_A_CVH, 8'h00, "half write");
    rdc(`TPC_A_CVL, 8'h00, "half write");
    wr(`TPC_A_CVL, 8'h34);
    rdc(`TPC_A_CVH, 8'h00, "before step");
    rdc(`TPC_A_CVL, 8'h00, "before step");
    pulses(1);
    rdc(`TPC_A_CVH, 8'h12, "after step");
    rdc(`TPC_A_CVL, 8'h34, "after step");
    rdc(`TPC_A_CVH, 8'h12, "value latch");
    wr(`TPC_A_CVH, 8'h56);
    wr(`TPC_A_CVL, 8'h78);
    pulses(1);
    debug_halt <= 1'b1;
    rdc(`TPC_A_CVL, 8'h78, "halt value");
    rdc(`TPC_A_CVH, 8'h56, "halt value high");
    wr(`TPC_A_CSC, 8'h05);
    debug_halt <= 1'b0;
    rdc(`TPC_A_CVL, 8'h78, "value latch reset");
    rdc(`TPC_A_CVH, 8'h56, "value high");
    wr(`TPC_A_MODH, 8'h00);
    wr(`TPC_A_MODL, 8'h04);
    wr(`TPC_A_CSC, 8'h08);
    wr(`TPC_A_CNTL, 8'h00);
    wr(`TPC_A_CVH, 8'h00);
    wr(`TPC_A_CVL, 8'h02);
    pulses(3);
    rdc(`TPC_A_CVH, 8'h56, "pwm hold");
    rdc(`TPC_A_CVL, 8'h78, "pwm hold");
    chk1(pa_out, 1'b1, "pwm output high");
    pulses(1);
    rdc(`TPC_A_CVH, 8'h00, "pwm load");
    rdc(`TPC_A_CVL, 8'h02, "pwm load");
    chk1(pb_out, 1'b0, "pwm output low");
    // routing first, so no pin edge can reach the capture logic
    wr(`TPC_A_OPT, 8'h01);
    wr(`TPC_A_CSC, 8'h01);
    u_far.cmp_drive(1'b1);
    rdc(`TPC_A_CSC, 8'h81, "capture flag");
    rdc(`TPC_A_CVH, 8'h00, "capture high");
    rdc(`TPC_A_CVL, 8'h04, "capture low");
    // free running pwm on the bus clock: the load waits for the step onto 0xffff
    wr(`TPC_A_MODL, 8'h00);
    wr(`TPC_A_CSC, 8'h08);
    wr(`TPC_A_CVH, 8'h00);
    wr(`TPC_A_CVL, 8'h09);
    wr(`TPC_A_TSC, 8'h08);
    rdc(`TPC_A_CVL, 8'h04, "free hold");
    rdc(`TPC_A_CVH, 8'h00, "free hold high");
    repeat (65600) @(posedge clk_sys);
    rdc(`TPC_A_CVL, 8'h09, "free load");
    rdc(`TPC_A_CVH, 8'h00, "free load high");
    // a second reset must set the gate again and restore the pin options
    wr(`TPC_A_GATE, 8'h00);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk1(gate_en, 1'b1, "gate after reset");
    rdc(`TPC_A_OPT, 8'h00, "option reset");
    complete_run();
  end
endmodule : test_timer_pwm_coherency
